// [hw/tur_params.svh]
`ifndef TUR_PARAMS_SVH
`define TUR_PARAMS_SVH
// Uplink and downlink format codes
`define TUR_UF_SURV_ALT   5'h04
`define TUR_UF_SURV_ID    5'h05
`define TUR_UF_COMMA_ALT  5'h14
`define TUR_UF_COMMA_ID   5'h15
`define TUR_DF_SURV_ALT   5'h04
`define TUR_DF_SURV_ID    5'h05
`define TUR_DF_COMMB_ALT  5'h14
`define TUR_DF_COMMB_ID   5'h15
// Reply request threshold
`define TUR_RR_COMMB      5'h10
// Designator codes
`define TUR_DI_NONE       3'h0
`define TUR_DI_MULTISITE  3'h1
`define TUR_DI_EXTREAD    3'h7
// Designator field layout
`define TUR_SD_IIS_MSB    15
`define TUR_SD_IIS_LSB    12
`define TUR_SD_RRS_MSB    7
`define TUR_SD_RRS_LSB    4
// Field widths and limits
`define TUR_MA_BITS       56
`define TUR_SD_BITS       16
`define TUR_ADDR_BITS     24
`define TUR_ADDR_BCAST    24'hFFFFFF
`define TUR_MAX_PARTS     4
`define TUR_SITES         16
// Linked component codes
`define TUR_PART_FIRST    2'h0
`define TUR_PART_SECOND   2'h1
`define TUR_PART_THIRD    2'h2
`define TUR_PART_FINAL    2'h3
`endif

// [hw/tur_pkg.sv]
`default_nettype none
package tur_pkg;
    typedef enum {TUR_IDLE, TUR_REPLY, TUR_LINK} tur_state_t;
    typedef logic [4:0] tur_fmt_t;
endpackage
`default_nettype wire

// [hw/tur_uplink_reply.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tur_params.svh"
module tur_uplink_reply
#(
    parameter int SITES = `TUR_SITES
)
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        upValid,
    input  wire logic [4:0]  upFormat,
    input  wire logic [4:0]  upRr,
    input  wire logic [2:0]  upDi,
    input  wire logic [15:0] upSd,
    input  wire logic [55:0] upMa,
    input  wire logic [23:0] upAddr,
    input  wire logic        upOwnAddr,
    input  wire logic        upLinked,
    input  wire logic [1:0]  upPart,
    input  wire logic        dataLinkFitted,
    input  wire logic        bdsSupported,
    input  wire logic [55:0] bdsData,
    input  wire logic [55:0] airMsg,
    output logic             bdsReq,
    output logic [7:0]       bdsCode,
    output logic             replyValid,
    output logic [4:0]       replyFormat,
    output logic [55:0]      replyMb,
    output logic             airRead,
    output logic             msgValid,
    output logic             msgBroadcast,
    output logic [55:0]      msgText,
    output logic [15:0]      msgSd,
    output logic             msgMultisite,
    output logic             msgExtRead,
    output logic             linkValid,
    output logic [3:0]       linkSite,
    output logic [1:0]       linkParts,
    output logic [223:0]     linkText
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Reply format from uplink format and RR
    function automatic tur_pkg::tur_fmt_t replyFmt(input logic [4:0] uf, input logic [4:0] rr);
        logic idReq;
        idReq = (uf == `TUR_UF_SURV_ID) || (uf == `TUR_UF_COMMA_ID);
        if (rr < `TUR_RR_COMMB)
            replyFmt = idReq ? `TUR_DF_SURV_ID : `TUR_DF_SURV_ALT;
        else
            replyFmt = idReq ? `TUR_DF_COMMB_ID : `TUR_DF_COMMB_ALT;
    endfunction

    // Data selector from RR and designator
    function automatic logic [7:0] selCode(input logic [4:0] rr, input logic [2:0] di,
                                           input logic [15:0] sd);
        logic [3:0] bds2;
        bds2 = (di == `TUR_DI_EXTREAD) ? sd[`TUR_SD_RRS_MSB:`TUR_SD_RRS_LSB] : 4'h0;
        selCode = {rr[3:0], bds2};
    endfunction

    logic       isSurv;
    logic       isCommA;
    logic       isBcast;
    logic       accepted;
    logic [7:0] sel;
    logic       wantB;
    logic       airReq;
    tur_pkg::tur_state_t state;

    // Interrogation classification
    assign isSurv   = (upFormat == `TUR_UF_SURV_ALT) || (upFormat == `TUR_UF_SURV_ID);
    assign isCommA  = (upFormat == `TUR_UF_COMMA_ALT) || (upFormat == `TUR_UF_COMMA_ID);
    assign isBcast  = isCommA && dataLinkFitted && (upAddr == `TUR_ADDR_BCAST);
    assign accepted = upValid && (isSurv || isCommA) && (upOwnAddr || isBcast);
    assign sel      = selCode(upRr, upDi, upSd);
    assign wantB    = upRr > `TUR_RR_COMMB;
    assign airReq   = (upRr == `TUR_RR_COMMB) && (sel[3:0] == 4'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: request data, then reply

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state <= tur_pkg::TUR_IDLE;
        else
        begin
            case (state)
                tur_pkg::TUR_IDLE:
                    if (accepted && !isBcast)
                        state <= tur_pkg::TUR_REPLY;
                tur_pkg::TUR_REPLY:
                    state <= tur_pkg::TUR_IDLE;
                default:
                    state <= tur_pkg::TUR_IDLE;
            endcase
        end
    end

    // Selector request toward data sources
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bdsReq  <= 1'b0;
            bdsCode <= 8'h00;
            airRead <= 1'b0;
        end
        else
        begin
            bdsReq  <= (state == tur_pkg::TUR_IDLE) && accepted && !isBcast && wantB;
            airRead <= (state == tur_pkg::TUR_IDLE) && accepted && !isBcast && airReq;
            if ((state == tur_pkg::TUR_IDLE) && accepted)
                bdsCode <= sel;
        end
    end

    // Reply generation, two cycles after acceptance
    logic       pendB;
    logic       pendAir;
    tur_pkg::tur_fmt_t pendFmt;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pendB   <= 1'b0;
            pendAir <= 1'b0;
            pendFmt <= 5'h00;
        end
        else if ((state == tur_pkg::TUR_IDLE) && accepted)
        begin
            pendB   <= wantB;
            pendAir <= airReq;
            pendFmt <= replyFmt(upFormat, upRr);
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            replyValid  <= 1'b0;
            replyFormat <= 5'h00;
            replyMb     <= 56'h0;
        end
        else
        begin
            replyValid <= (state == tur_pkg::TUR_REPLY);
            if (state == tur_pkg::TUR_REPLY)
            begin
                replyFormat <= pendFmt;
                if (pendB)
                    replyMb <= bdsSupported ? bdsData : 56'h0;
                else if (pendAir)
                    replyMb <= airMsg;
                else
                    replyMb <= 56'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Received uplink message text

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            msgValid     <= 1'b0;
            msgBroadcast <= 1'b0;
            msgText      <= 56'h0;
            msgSd        <= 16'h0000;
            msgMultisite <= 1'b0;
            msgExtRead   <= 1'b0;
        end
        else
        begin
            msgValid <= (state == tur_pkg::TUR_IDLE) && accepted && isCommA && !upLinked;
            if ((state == tur_pkg::TUR_IDLE) && accepted && isCommA)
            begin
                msgText      <= upMa;
                msgBroadcast <= isBcast;
                msgSd        <= (upDi == `TUR_DI_NONE) ? 16'h0000 : upSd;
                msgMultisite <= upDi == `TUR_DI_MULTISITE;
                msgExtRead   <= upDi == `TUR_DI_EXTREAD;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Linked message assembly, per site

    logic [55:0] partBuf [SITES][`TUR_MAX_PARTS];
    logic [3:0]  partSeen [SITES];
    logic [3:0]  site;
    logic        linkIn;
    logic        finalDone;
    assign site      = upSd[`TUR_SD_IIS_MSB:`TUR_SD_IIS_LSB];
    assign linkIn    = (state == tur_pkg::TUR_IDLE) && accepted && isCommA && !isBcast
                       && upLinked && (upDi == `TUR_DI_MULTISITE);
    assign finalDone = linkIn && (upPart == `TUR_PART_FINAL) && partSeen[site][0];

    // Component storage; first part clears the site's partial message
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int s = 0; s < SITES; s++)
            begin
                partSeen[s] <= 4'h0;
                for (int p = 0; p < `TUR_MAX_PARTS; p++)
                    partBuf[s][p] <= 56'h0;
            end
        end
        else if (linkIn)
        begin
            if (upPart == `TUR_PART_FIRST)
            begin
                partSeen[site] <= 4'h1;
                partBuf[site][0] <= upMa;
            end
            else if (finalDone)
                partSeen[site] <= 4'h0;
            else if (partSeen[site][0])
            begin
                partSeen[site][upPart] <= 1'b1;
                partBuf[site][upPart] <= upMa;
            end
        end
    end

    // Release of complete message, packed first part highest
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            linkValid <= 1'b0;
            linkSite  <= 4'h0;
            linkParts <= 2'h0;
            linkText  <= 224'h0;
        end
        else
        begin
            linkValid <= finalDone;
            if (finalDone)
            begin
                linkSite <= site;
                // Count of parts minus one: 1, 2 or 3 for two to four parts
                linkParts <= 2'(2'h1 + 2'(partSeen[site][1]) + 2'(partSeen[site][2]));
                linkText <= {partBuf[site][0],
                             partSeen[site][1] ? partBuf[site][1] : 56'h0,
                             partSeen[site][2] ? partBuf[site][2] : 56'h0,
                             upMa};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_reply_after_accept;
        @(posedge clk) disable iff (!nrst)
        (state == tur_pkg::TUR_IDLE && accepted && !isBcast) |-> ##2 replyValid;
    endproperty
    a_reply_after_accept: assert property (p_reply_after_accept) else $error("no reply");

    property p_bcast_silent;
        @(posedge clk) disable iff (!nrst)
        (state == tur_pkg::TUR_IDLE && accepted && isBcast) |-> ##2 !replyValid;
    endproperty
    a_bcast_silent: assert property (p_bcast_silent) else $error("broadcast replied");

    property p_short_fmt;
        @(posedge clk) disable iff (!nrst)
        (state == tur_pkg::TUR_IDLE && accepted && !isBcast && upRr < 5'h10
         && upFormat == 5'h04) |-> ##2 replyFormat == 5'h04;
    endproperty
    a_short_fmt: assert property (p_short_fmt) else $error("bad short format");

    property p_id_fmt;
        @(posedge clk) disable iff (!nrst)
        (state == tur_pkg::TUR_IDLE && accepted && !isBcast && upRr >= 5'h10
         && upFormat == 5'h05) |-> ##2 replyFormat == 5'h15;
    endproperty
    a_id_fmt: assert property (p_id_fmt) else $error("bad id format");

    property p_bds1;
        @(posedge clk) disable iff (!nrst)
        bdsReq |-> bdsCode[7:4] == 4'($past(upRr) - 5'h10);
    endproperty
    a_bds1: assert property (p_bds1) else $error("bad BDS1");

    property p_bds2;
        @(posedge clk) disable iff (!nrst)
        (bdsReq && $past(upDi) != 3'h7) |-> bdsCode[3:0] == 4'h0;
    endproperty
    a_bds2: assert property (p_bds2) else $error("bad BDS2");

    property p_zero_mb;
        @(posedge clk) disable iff (!nrst)
        (bdsReq && !bdsSupported) |=> replyValid && replyMb == 56'h0;
    endproperty
    a_zero_mb: assert property (p_zero_mb) else $error("MB not zero");

    property p_di_zero;
        @(posedge clk) disable iff (!nrst)
        (msgValid && $past(upDi) == 3'h0) |-> msgSd == 16'h0000;
    endproperty
    a_di_zero: assert property (p_di_zero) else $error("SD not ignored");

    property p_air_read;
        @(posedge clk) disable iff (!nrst)
        airRead |=> replyValid && replyMb == $past(airMsg) && !$past(bdsReq);
    endproperty
    a_air_read: assert property (p_air_read) else $error("air read as readout");

    c_readout: cover property (@(posedge clk) disable iff (!nrst) bdsReq ##1 replyValid);
    c_bcast: cover property (@(posedge clk) disable iff (!nrst) msgValid && msgBroadcast);
    c_linked: cover property (@(posedge clk) disable iff (!nrst) linkValid && linkParts == 2'h3);

endmodule
`default_nettype wire

// [bench/tur_interrogator.sv]
`timescale 1ns/1ps
`default_nettype none
// Ground interrogator model that drives the uplink fields
module tur_interrogator
(
    input  wire logic   clk,
    input  wire logic   replyValid,
    output logic        upValid,
    output logic [4:0]  upFormat,
    output logic [4:0]  upRr,
    output logic [2:0]  upDi,
    output logic [15:0] upSd,
    output logic [55:0] upMa,
    output logic [23:0] upAddr,
    output logic        upOwnAddr,
    output logic        upLinked,
    output logic [1:0]  upPart
);
    // Quiet uplink at start
    initial
    begin
        {upValid, upFormat, upRr, upDi, upSd, upMa, upAddr, upOwnAddr, upLinked, upPart} = '0;
    end

    ////////////////////////////////////////
    // One interrogation, repeated while no reply comes back
    task automatic send(input logic [4:0] f, r, input logic [2:0] d, input logic [15:0] s,
                        input logic [55:0] m, input logic [23:0] a, input logic o,
                        input logic [2:0] k, input int t, output logic got);
        int n;
        int w;
        got = 1'b0;
        for (n = 0; n < t && !got; n++)
        begin
            @(posedge clk);
            upFormat <= f;
            upRr <= r;
            upDi <= d;
            upSd <= s;
            upMa <= m;
            upAddr <= a;
            upOwnAddr <= o;
            upLinked <= k[2];
            upPart <= k[1:0];
            upValid <= 1'b1;
            @(posedge clk);
            upValid <= 1'b0;
            upSd <= ~s; // Released fields stop showing the message
            upMa <= ~m;
            for (w = 0; w < 4 && !got; w++)
            begin
                @(negedge clk); // Reply looked at mid-cycle, where it has settled
                got = replyValid;
            end
        end
    endtask
endmodule
`default_nettype wire

// [bench/transponder_uplink_reply_logic_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin fails++; $display("BAD %s exp %0h got %0h", n, (e), (s)); end end
module transponder_uplink_reply_logic_tb;
    logic         clk = 1'b0;
    logic         nrst = 1'b0;
    logic         dataLinkFitted = 1'b1;
    logic         bdsSupported = 1'b0;
    logic [55:0]  bdsData = 56'h0;
    logic [55:0]  airMsg = 56'h5A5A5A5A5A5A5A;
    logic         upValid, upOwnAddr, upLinked, bdsReq, replyValid, airRead, got;
    logic         msgValid, msgBroadcast, msgMultisite, msgExtRead, linkValid;
    logic [1:0]   upPart, linkParts;
    logic [2:0]   upDi;
    logic [3:0]   linkSite;
    logic [4:0]   upFormat, upRr, replyFormat;
    logic [7:0]   bdsCode;
    logic [15:0]  upSd, msgSd;
    logic [23:0]  upAddr;
    logic [55:0]  upMa, replyMb, msgText;
    logic [223:0] linkText;
    int           fails = 0, tests_run = 0, cyc = 0, upCyc, repCyc;
    int           nRep, nMsg, nLink, nAir, nBds;

    // 25 MHz clock
    always #20 clk = ~clk;

    tur_uplink_reply u_tur_uplink_reply (.clk, .nrst, .upValid, .upFormat, .upRr, .upDi,
        .upSd, .upMa, .upAddr, .upOwnAddr, .upLinked, .upPart, .dataLinkFitted, .bdsSupported,
        .bdsData, .airMsg, .bdsReq, .bdsCode, .replyValid, .replyFormat, .replyMb, .airRead,
        .msgValid, .msgBroadcast, .msgText, .msgSd, .msgMultisite, .msgExtRead, .linkValid,
        .linkSite, .linkParts, .linkText);

    tur_interrogator u_tur_interrogator (.clk, .replyValid, .upValid, .upFormat, .upRr,
        .upDi, .upSd, .upMa, .upAddr, .upOwnAddr, .upLinked, .upPart);

    // Pulse counters and timing of request and reply, sampled mid-cycle
    always @(negedge clk)
    begin
        cyc <= cyc + 1;
        if (upValid)
            upCyc <= cyc;
        if (replyValid)
        begin
            nRep <= nRep + 1;
            repCyc <= cyc;
        end
        nMsg <= nMsg + int'(msgValid);
        nLink <= nLink + int'(linkValid);
        nAir <= nAir + int'(airRead);
        nBds <= nBds + int'(bdsReq);
    end

    ////////////////////////////////////////
    // One transaction, then let the outputs land
    task automatic go(input logic [4:0] f, r, input logic [2:0] d, input logic [15:0] s,
                      input logic [55:0] m, input logic [23:0] a, input logic o,
                      input logic [2:0] k, input int t);
        {nRep, nMsg, nLink, nAir, nBds} = '0;
        u_tur_interrogator.send(f, r, d, s, m, a, o, k, t, got);
        repeat (2) @(posedge clk);
    endtask

    task automatic t_formats();
        logic [4:0]  uf [4] = '{5'h04, 5'h05, 5'h14, 5'h15};
        logic [4:0]  rr [3] = '{5'h00, 5'h0F, 5'h10};
        logic [55:0] m;
        for (int i = 0; i < 4; i++)
            for (int j = 0; j < 3; j++)
            begin
                m = 56'h0123456789ABC0 + 56'(i * 3 + j);
                go(uf[i], rr[j], 3'h0, 16'hA5C3, m, 24'h1, 1'b1, 3'h0, 2);
                `CHK("ack", 1'b1, got)
                `CHK("lat", 2, repCyc - upCyc)
                `CHK("df", rr[j][4] ? (uf[i] | 5'h10) : (uf[i] & 5'h0F), replyFormat)
                `CHK("air", int'(rr[j][4]), nAir)
                `CHK("nobds", 0, nBds)
                `CHK("msg", int'(uf[i][4]), nMsg)
                if (rr[j][4])
                    `CHK("airmb", airMsg, replyMb)
                if (uf[i][4])
                begin
                    `CHK("txt", m, msgText)
                    `CHK("sd0", 16'h0, msgSd)
                end
            end
        go(5'h15, 5'h00, 3'h1, 16'h7ABC, m, 24'h1, 1'b1, 3'h0, 2);
        `CHK("multi", 1'b1, msgMultisite)
        `CHK("sdpass", 16'h7ABC, msgSd)
        go(5'h04, 5'h10, 3'h7, 16'h000F, m, 24'h1, 1'b1, 3'h0, 2);
        `CHK("air7", 1, nAir)
        `CHK("nobds7", 0, nBds)
        `CHK("air7mb", airMsg, replyMb)
    endtask

    // Ground readout with a given selector and support
    task automatic rd(input logic [4:0] f, r, input logic [2:0] d, input logic [15:0] s,
                      input logic sup, input logic [7:0] code);
        @(posedge clk);
        bdsSupported <= sup;
        bdsData <= {7{code}};
        go(f, r, d, s, 56'h1, 24'h1, 1'b1, 3'h0, 2);
        `CHK("bdsreq", 1, nBds)
        `CHK("code", code, bdsCode)
        `CHK("mb", sup ? {7{code}} : 56'h0, replyMb)
        `CHK("ext", d == 3'h7, msgExtRead)
        `CHK("dfb", f | 5'h10, replyFormat)
    endtask

    task automatic t_read();
        rd(5'h14, 5'h13, 3'h7, 16'h0050, 1'b1, 8'h35);
        rd(5'h15, 5'h1F, 3'h0, 16'h00F0, 1'b1, 8'hF0);
        rd(5'h14, 5'h12, 3'h7, 16'h0090, 1'b0, 8'h29);
        rd(5'h15, 5'h11, 3'h1, 16'h0030, 1'b0, 8'h10);
    endtask

    // One linked component from a site
    task automatic lk(input logic [3:0] s, input logic [1:0] p, input logic [55:0] m);
        go(5'h14, 5'h00, 3'h1, {s, 12'h0A0}, m, 24'h1, 1'b1, {1'b1, p}, 2);
        `CHK("lack", 1'b1, got)
        `CHK("lmsg", 0, nMsg)
        if (p != 2'h3)
            `CHK("hold", 0, nLink)
    endtask

    task automatic fin(input logic [3:0] s, input logic [1:0] n, input logic [223:0] x);
        `CHK("lnk", 1, nLink)
        `CHK("site", s, linkSite)
        `CHK("parts", n, linkParts)
        `CHK("ltext", x, linkText)
    endtask

    task automatic t_linked();
        lk(4'h3, 2'h0, 56'hA);
        lk(4'h3, 2'h2, 56'hC);
        lk(4'h3, 2'h1, 56'hB);
        lk(4'h3, 2'h3, 56'hD);
        fin(4'h3, 2'h3, {56'hA, 56'hB, 56'hC, 56'hD});
        lk(4'h5, 2'h0, 56'hE);
        lk(4'h3, 2'h0, 56'hF);
        lk(4'h3, 2'h1, 56'h6);
        lk(4'h3, 2'h0, 56'h7);
        lk(4'h5, 2'h3, 56'h8);
        fin(4'h5, 2'h1, {56'hE, 112'h0, 56'h8});
        lk(4'h3, 2'h3, 56'h9);
        fin(4'h3, 2'h1, {56'h7, 112'h0, 56'h9});
        lk(4'h9, 2'h3, 56'h1);
        `CHK("orphan", 0, nLink)
    endtask

    task automatic t_bcast();
        repeat (2)
        begin
            go(5'h14, 5'h00, 3'h0, 16'h0, 56'hB0CA57, 24'hFFFFFF, 1'b0, 3'h0, 1);
            `CHK("norep", 1'b0, got)
            `CHK("bmsg", 1, nMsg)
            `CHK("bflag", 1'b1, msgBroadcast)
            `CHK("btxt", 56'hB0CA57, msgText)
        end
        go(5'h15, 5'h00, 3'h0, 16'h0, 56'h1, 24'hABCDEF, 1'b0, 3'h0, 1);
        `CHK("foreign", 0, nMsg + nRep)
        @(posedge clk);
        dataLinkFitted <= 1'b0;
        go(5'h14, 5'h00, 3'h0, 16'h0, 56'h2, 24'hFFFFFF, 1'b0, 3'h0, 1);
        `CHK("nolink", 0, nMsg + nRep)
        dataLinkFitted <= 1'b1;
    endtask

    task automatic end_of_test();
        if (fails == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        `CHK("rst", 0, {replyValid, replyFormat, bdsCode, msgText, linkText})
        t_formats();
        t_read();
        t_linked();
        t_bcast();
        end_of_test();
    end

    // Hang guard
    initial
    begin
        #400000;
        fails++;
        end_of_test();
    end
endmodule
`default_nettype wire
